// ==== hw/sdcmd_pkg.sv ====
package sdcmd_pkg;
  localparam int unsigned BANKS = 4;
  localparam int unsigned BANK_W = 2;
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned PRECHARGE_SELECT_BIT = 10;
  localparam int unsigned BURST_LEN = 8;
  localparam int unsigned CORE_CLK_NS = 50;
  localparam int unsigned LINK_HALF_CYC = 4;
  localparam int unsigned SELF_REFRESH_EXIT_TIME_NS = 120;
  localparam int unsigned SELF_REFRESH_EXIT_CYC =
    (SELF_REFRESH_EXIT_TIME_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int unsigned CLOCK_GATE_SETUP_TIME_NS = 2;
  localparam int unsigned LINK_CK_MIN_NS = 6;
  localparam int unsigned WAKE_HOLD_CYC =
    (CLOCK_GATE_SETUP_TIME_NS + LINK_CK_MIN_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int unsigned REFRESH_BURST = 8192;
  localparam int unsigned PD_LIMIT_CYC = 100000;
  // Row strobe, column strobe, write enable
  localparam logic [2:0] RCW_MRS = 3'h0;
  localparam logic [2:0] RCW_REF = 3'h1;
  localparam logic [2:0] RCW_PRE = 3'h2;
  localparam logic [2:0] RCW_ACT = 3'h3;
  localparam logic [2:0] RCW_WRITE = 3'h4;
  localparam logic [2:0] RCW_READ = 3'h5;
  localparam logic [2:0] RCW_BST = 3'h6;
  localparam logic [2:0] RCW_NOP = 3'h7;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_ACT = 4'h1,
    OP_READ = 4'h2,
    OP_WRITE = 4'h3,
    OP_PRE = 4'h4,
    OP_REF = 4'h5,
    OP_MRS = 4'h6,
    OP_BST = 4'h7,
    OP_SREF = 4'h8,
    OP_PDOWN = 4'h9,
    OP_WAKE = 4'hA
  } sdcmd_op_e;
  typedef enum logic [1:0] {
    MD_RUN = 2'h0,
    MD_SREF = 2'h1,
    MD_PDOWN = 2'h2,
    MD_SUSP = 2'h3
  } sdcmd_mode_e;
endpackage

// ==== hw/sdcmd_link_if.sv ====
`timescale 1ns/100ps
interface sdcmd_link_if;
  logic link_clk;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [sdcmd_pkg::BANK_W-1:0] bank_select;
  logic [sdcmd_pkg::ADDR_W-1:0] addr;
  modport ctrl (output link_clk, cke, cs_n, ras_n, cas_n, we_n, bank_select, addr);
  modport dev (input link_clk, cke, cs_n, ras_n, cas_n, we_n, bank_select, addr);
endinterface

// ==== hw/sdcmd_sync.sv ====
`timescale 1ns/100ps
module sdcmd_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  generate
    if (W < 1) begin : g_bad_w
      $error("W must be at least 1");
    end
  endgenerate

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// ==== hw/sdcmd_dev.sv ====
`timescale 1ns/100ps
module sdcmd_dev #(
  parameter int unsigned BURST_LEN = sdcmd_pkg::BURST_LEN
) (
  input wire logic CORE_CLK_I,
  input wire logic ARST_N_I,
  sdcmd_link_if.dev LINK,
  input wire logic FULL_PAGE_I,
  output logic CMD_VALID_O,
  output sdcmd_pkg::sdcmd_op_e CMD_O,
  output logic [sdcmd_pkg::BANK_W-1:0] BANK_O,
  output logic [sdcmd_pkg::ADDR_W-1:0] ADDR_O,
  output logic AUTO_PRE_O,
  output logic [sdcmd_pkg::BANKS-1:0] BANK_ACTIVE_O,
  output logic BURST_ACTIVE_O,
  output logic BURST_BEAT_O,
  output sdcmd_pkg::sdcmd_mode_e MODE_O,
  output logic INT_CLK_EN_O
);
  localparam int unsigned BCW = $clog2(BURST_LEN + 1);
  localparam int unsigned PW = 6 + sdcmd_pkg::BANK_W + sdcmd_pkg::ADDR_W;

  generate
    if (BURST_LEN < 1 || BURST_LEN > 512) begin : g_bad_len
      $error("BURST_LEN out of range");
    end
  endgenerate

  logic [PW-1:0] pin_raw;
  logic [PW-1:0] pin_s;
  logic ck_s;
  logic cke_s;
  logic cs_n_s;
  logic [2:0] rcw_s;
  logic [sdcmd_pkg::BANK_W-1:0] bank_s;
  logic [sdcmd_pkg::ADDR_W-1:0] addr_s;
  logic rise;

  logic ck_d;
  logic cke_prev;
  logic [BCW-1:0] burst_cnt;
  logic [sdcmd_pkg::BANK_W-1:0] burst_bank;
  logic burst_ap;

  logic next_ck_d;
  logic next_cke_prev;
  logic [BCW-1:0] next_cnt;
  logic [sdcmd_pkg::BANK_W-1:0] next_bbank;
  logic next_ap;
  logic next_valid;
  sdcmd_pkg::sdcmd_op_e next_cmd;
  logic [sdcmd_pkg::BANK_W-1:0] next_bank;
  logic [sdcmd_pkg::ADDR_W-1:0] next_addr;
  logic next_auto;
  logic [sdcmd_pkg::BANKS-1:0] next_active;
  logic next_burst;
  logic next_beat;
  sdcmd_pkg::sdcmd_mode_e next_mode;
  logic next_clk_en;
  sdcmd_pkg::sdcmd_op_e op;
  logic pre_sel;

  assign pin_raw = {LINK.link_clk, LINK.cke, LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n,
                    LINK.bank_select, LINK.addr};
  assign {ck_s, cke_s, cs_n_s, rcw_s, bank_s, addr_s} = pin_s;
  assign rise = ck_s & ~ck_d;
  assign pre_sel = addr_s[sdcmd_pkg::PRECHARGE_SELECT_BIT];

  // Link pins and link clock cross into the core clock here
  sdcmd_sync #(.W(PW)) u_pin_sync (
    .clk_i(CORE_CLK_I),
    .arst_n_i(ARST_N_I),
    .d_i(pin_raw),
    .q_o(pin_s)
  );

  always_comb begin
    next_ck_d = ck_s;
    next_cke_prev = cke_prev;
    next_cnt = burst_cnt;
    next_bbank = burst_bank;
    next_ap = burst_ap;
    next_valid = 1'b0;
    next_cmd = CMD_O;
    next_bank = BANK_O;
    next_addr = ADDR_O;
    next_auto = AUTO_PRE_O;
    next_active = BANK_ACTIVE_O;
    next_burst = BURST_ACTIVE_O;
    next_beat = 1'b0;
    next_mode = MODE_O;
    next_clk_en = INT_CLK_EN_O;
    op = sdcmd_pkg::OP_NOP;
    if (rise) begin
      next_cke_prev = cke_s;
      if (MODE_O != sdcmd_pkg::MD_RUN) begin
        // Only clock enable is watched while asleep or suspended
        if (!cke_prev && cke_s) begin
          next_mode = sdcmd_pkg::MD_RUN;
        end
      end else if (cke_prev) begin
        if (cs_n_s) begin
          op = sdcmd_pkg::OP_NOP;
        end else begin
          case (rcw_s)
            sdcmd_pkg::RCW_ACT: op = sdcmd_pkg::OP_ACT;
            sdcmd_pkg::RCW_READ: op = sdcmd_pkg::OP_READ;
            sdcmd_pkg::RCW_WRITE: op = sdcmd_pkg::OP_WRITE;
            sdcmd_pkg::RCW_PRE: op = sdcmd_pkg::OP_PRE;
            sdcmd_pkg::RCW_REF: op = cke_s ? sdcmd_pkg::OP_REF : sdcmd_pkg::OP_SREF;
            sdcmd_pkg::RCW_MRS: op = sdcmd_pkg::OP_MRS;
            sdcmd_pkg::RCW_BST: op = sdcmd_pkg::OP_BST;
            sdcmd_pkg::RCW_NOP: op = sdcmd_pkg::OP_NOP;
            default: op = sdcmd_pkg::OP_NOP;
          endcase
        end
        // Running burst advances first; a no-op leaves it running
        if (BURST_ACTIVE_O) begin
          next_beat = 1'b1;
          if (!FULL_PAGE_I) begin
            next_cnt = burst_cnt - BCW'(1);
            if (burst_cnt == BCW'(1)) begin
              next_burst = 1'b0;
              if (burst_ap) begin
                next_active[burst_bank] = 1'b0;
              end
            end
          end
        end
        case (op)
          sdcmd_pkg::OP_ACT: begin
            next_active[bank_s] = 1'b1;
          end
          sdcmd_pkg::OP_PRE: begin
            if (pre_sel) begin
              next_active = '0;
            end else begin
              next_active[bank_s] = 1'b0;
            end
          end
          sdcmd_pkg::OP_READ, sdcmd_pkg::OP_WRITE: begin
            next_beat = 1'b1;
            next_bbank = bank_s;
            next_ap = pre_sel;
            next_cnt = BCW'(BURST_LEN - 1);
            next_burst = FULL_PAGE_I || (BURST_LEN > 1);
            if (!next_burst && pre_sel) begin
              next_active[bank_s] = 1'b0;
            end
          end
          sdcmd_pkg::OP_BST: begin
            if (FULL_PAGE_I) begin
              next_burst = 1'b0;
            end
          end
          default: begin
          end
        endcase
        if (op != sdcmd_pkg::OP_NOP) begin
          next_valid = 1'b1;
          next_cmd = op;
          next_bank = bank_s;
          next_addr = addr_s;
          next_auto = pre_sel;
        end
        // Falling clock enable picks the low-power state
        if (!cke_s) begin
          if (op == sdcmd_pkg::OP_SREF && next_active == '0 && !next_burst) begin
            next_mode = sdcmd_pkg::MD_SREF;
          end else if (next_active != '0 || next_burst) begin
            next_mode = sdcmd_pkg::MD_SUSP;
          end else begin
            next_mode = sdcmd_pkg::MD_PDOWN;
          end
        end
      end
      // Internal clock runs only when the last sampled enable was high
      next_clk_en = (next_mode == sdcmd_pkg::MD_RUN) && next_cke_prev;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ck_d <= 1'b0;
      cke_prev <= 1'b0;
      burst_cnt <= '0;
      burst_bank <= '0;
      burst_ap <= 1'b0;
      CMD_VALID_O <= 1'b0;
      CMD_O <= sdcmd_pkg::OP_NOP;
      BANK_O <= '0;
      ADDR_O <= '0;
      AUTO_PRE_O <= 1'b0;
      BANK_ACTIVE_O <= '0;
      BURST_ACTIVE_O <= 1'b0;
      BURST_BEAT_O <= 1'b0;
      MODE_O <= sdcmd_pkg::MD_RUN;
      INT_CLK_EN_O <= 1'b0;
    end else begin
      ck_d <= next_ck_d;
      cke_prev <= next_cke_prev;
      burst_cnt <= next_cnt;
      burst_bank <= next_bbank;
      burst_ap <= next_ap;
      CMD_VALID_O <= next_valid;
      CMD_O <= next_cmd;
      BANK_O <= next_bank;
      ADDR_O <= next_addr;
      AUTO_PRE_O <= next_auto;
      BANK_ACTIVE_O <= next_active;
      BURST_ACTIVE_O <= next_burst;
      BURST_BEAT_O <= next_beat;
      MODE_O <= next_mode;
      INT_CLK_EN_O <= next_clk_en;
    end
  end
endmodule

// ==== hw/sdcmd_host.sv ====
`timescale 1ns/100ps
module sdcmd_host #(
  parameter int unsigned LINK_HALF = sdcmd_pkg::LINK_HALF_CYC,
  parameter int unsigned REFRESH_BURST = sdcmd_pkg::REFRESH_BURST,
  parameter int unsigned PD_LIMIT = sdcmd_pkg::PD_LIMIT_CYC
) (
  input wire logic CORE_CLK_I,
  input wire logic ARST_N_I,
  sdcmd_link_if.ctrl LINK,
  input wire logic REQ_I,
  input wire sdcmd_pkg::sdcmd_op_e OP_I,
  input wire logic [sdcmd_pkg::BANK_W-1:0] BANK_I,
  input wire logic [sdcmd_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic FULL_PAGE_I,
  output logic BUSY_O,
  output logic ACK_O,
  output logic REFUSE_O,
  output sdcmd_pkg::sdcmd_mode_e MODE_O
);
  generate
    if (LINK_HALF < 3 || LINK_HALF > 255 || REFRESH_BURST > 65535 || PD_LIMIT < 1) begin : g_bad
      $error("sdcmd_host parameter out of range");
    end
  endgenerate

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_REFB = 3'h1,
    H_SREF = 3'h2,
    H_PDOWN = 3'h3,
    H_EXIT = 3'h4
  } sdcmd_hst_e;

  sdcmd_hst_e state, next_state;
  logic [7:0] div_cnt, next_div;
  logic ck, next_ck, fall;
  logic cke, next_cke, cs_n, next_cs_n;
  logic [2:0] rcw, next_rcw;
  logic [sdcmd_pkg::BANK_W-1:0] bank, next_bank, p_bank, next_pbank;
  logic [sdcmd_pkg::ADDR_W-1:0] addr, next_addr, p_addr, next_paddr;
  sdcmd_pkg::sdcmd_op_e p_op, next_op;
  logic [sdcmd_pkg::BANKS-1:0] active, next_active;
  logic [15:0] refs, next_refs;
  logic ref_ph, next_ref_ph, post, next_post;
  logic [31:0] tmr, next_tmr;
  logic next_busy, next_ack, next_refuse;
  sdcmd_pkg::sdcmd_mode_e next_mode;

  assign LINK.link_clk = ck;
  assign LINK.cke = cke;
  assign LINK.cs_n = cs_n;
  assign {LINK.ras_n, LINK.cas_n, LINK.we_n} = rcw;
  assign LINK.bank_select = bank;
  assign LINK.addr = addr;

  always_comb begin
    next_div = div_cnt + 8'h01;
    next_ck = ck;
    fall = 1'b0;
    if (div_cnt == 8'(LINK_HALF - 1)) begin
      next_div = 8'h00;
      next_ck = ~ck;
      fall = ck;
    end
    next_state = state;
    next_cke = cke;
    next_cs_n = cs_n;
    next_rcw = rcw;
    next_bank = bank;
    next_addr = addr;
    next_active = active;
    next_refs = refs;
    next_ref_ph = ref_ph;
    next_post = post;
    next_tmr = (tmr != 32'h0) ? tmr - 32'h1 : 32'h0;
    next_busy = BUSY_O;
    next_ack = 1'b0;
    next_refuse = 1'b0;
    next_mode = MODE_O;
    next_op = p_op;
    next_pbank = p_bank;
    next_paddr = p_addr;
    if (REQ_I && !BUSY_O) begin
      next_busy = 1'b1;
      next_op = OP_I;
      next_pbank = BANK_I;
      next_paddr = ADDR_I;
    end
    // Pins change on the falling link edge, stable at the rising one
    if (fall) begin
      next_cs_n = 1'b0;
      next_rcw = sdcmd_pkg::RCW_NOP;
      case (state)
        H_IDLE: begin
          if (BUSY_O) begin
            next_bank = p_bank;
            next_addr = p_addr;
            next_ack = 1'b1;
            next_busy = 1'b0;
            case (p_op)
              sdcmd_pkg::OP_ACT: begin
                next_rcw = sdcmd_pkg::RCW_ACT;
                next_active[p_bank] = 1'b1;
              end
              sdcmd_pkg::OP_READ, sdcmd_pkg::OP_WRITE: begin
                if (active[p_bank]) begin
                  next_rcw = (p_op == sdcmd_pkg::OP_READ) ? sdcmd_pkg::RCW_READ : sdcmd_pkg::RCW_WRITE;
                  if (p_addr[sdcmd_pkg::PRECHARGE_SELECT_BIT]) begin
                    next_active[p_bank] = 1'b0;
                  end
                end else begin
                  next_ack = 1'b0;
                  next_refuse = 1'b1;
                end
              end
              sdcmd_pkg::OP_PRE: begin
                next_rcw = sdcmd_pkg::RCW_PRE;
                if (p_addr[sdcmd_pkg::PRECHARGE_SELECT_BIT]) begin
                  next_active = '0;
                end else begin
                  next_active[p_bank] = 1'b0;
                end
              end
              sdcmd_pkg::OP_REF: next_rcw = sdcmd_pkg::RCW_REF;
              sdcmd_pkg::OP_MRS: next_rcw = sdcmd_pkg::RCW_MRS;
              sdcmd_pkg::OP_NOP: next_rcw = sdcmd_pkg::RCW_NOP;
              sdcmd_pkg::OP_BST: begin
                if (FULL_PAGE_I) begin
                  next_rcw = sdcmd_pkg::RCW_BST;
                end else begin
                  next_ack = 1'b0;
                  next_refuse = 1'b1;
                end
              end
              sdcmd_pkg::OP_SREF: begin
                next_rcw = sdcmd_pkg::RCW_PRE;
                next_addr[sdcmd_pkg::PRECHARGE_SELECT_BIT] = 1'b1;
                next_active = '0;
                next_ack = 1'b0;
                next_busy = 1'b1;
                next_refs = 16'(REFRESH_BURST);
                next_ref_ph = 1'b0;
                next_post = 1'b0;
                next_state = H_REFB;
              end
              sdcmd_pkg::OP_PDOWN: begin
                next_cke = 1'b0;
                next_cs_n = 1'b1;
                next_tmr = 32'(PD_LIMIT);
                next_mode = (active != '0) ? sdcmd_pkg::MD_SUSP : sdcmd_pkg::MD_PDOWN;
                next_state = H_PDOWN;
              end
              default: begin
                next_ack = 1'b0;
                next_refuse = 1'b1;
              end
            endcase
          end
        end
        H_REFB: begin
          // Each refresh is followed by one no-op
          if (!ref_ph) begin
            next_ref_ph = 1'b1;
          end else if (refs == 16'h0) begin
            next_ack = 1'b1;
            next_busy = 1'b0;
            if (post) begin
              next_state = H_IDLE;
              next_mode = sdcmd_pkg::MD_RUN;
            end else begin
              next_rcw = sdcmd_pkg::RCW_REF;
              next_cke = 1'b0;
              next_mode = sdcmd_pkg::MD_SREF;
              next_state = H_SREF;
            end
          end else begin
            next_rcw = sdcmd_pkg::RCW_REF;
            next_refs = refs - 16'h1;
            next_ref_ph = 1'b0;
          end
        end
        H_SREF: begin
          if (BUSY_O && p_op == sdcmd_pkg::OP_WAKE) begin
            next_cke = 1'b1;
            next_cs_n = 1'b1;
            next_tmr = 32'(sdcmd_pkg::SELF_REFRESH_EXIT_CYC);
            next_post = 1'b1;
            next_state = H_EXIT;
          end else if (BUSY_O) begin
            next_busy = 1'b0;
            next_refuse = 1'b1;
          end
        end
        H_PDOWN: begin
          next_cs_n = 1'b1;
          if ((BUSY_O && p_op == sdcmd_pkg::OP_WAKE) || tmr == 32'h0) begin
            next_cke = 1'b1;
            next_cs_n = 1'b0;
            next_tmr = 32'(sdcmd_pkg::WAKE_HOLD_CYC);
            next_post = 1'b0;
            next_state = H_EXIT;
          end else if (BUSY_O) begin
            next_busy = 1'b0;
            next_refuse = 1'b1;
          end
        end
        H_EXIT: begin
          if (tmr == 32'h0) begin
            if (post && REFRESH_BURST > 0) begin
              next_refs = 16'(REFRESH_BURST);
              next_ref_ph = 1'b1;
              next_state = H_REFB;
            end else begin
              next_state = H_IDLE;
              next_mode = sdcmd_pkg::MD_RUN;
              if (BUSY_O && p_op == sdcmd_pkg::OP_WAKE) begin
                next_ack = 1'b1;
                next_busy = 1'b0;
              end
            end
          end
        end
        default: next_state = H_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state <= H_IDLE;
      div_cnt <= 8'h00;
      ck <= 1'b0;
      cke <= 1'b1;
      cs_n <= 1'b1;
      rcw <= sdcmd_pkg::RCW_NOP;
      bank <= '0;
      addr <= '0;
      p_op <= sdcmd_pkg::OP_NOP;
      p_bank <= '0;
      p_addr <= '0;
      active <= '0;
      refs <= 16'h0;
      ref_ph <= 1'b0;
      post <= 1'b0;
      tmr <= 32'h0;
      BUSY_O <= 1'b0;
      ACK_O <= 1'b0;
      REFUSE_O <= 1'b0;
      MODE_O <= sdcmd_pkg::MD_RUN;
    end else begin
      state <= next_state;
      div_cnt <= next_div;
      ck <= next_ck;
      cke <= next_cke;
      cs_n <= next_cs_n;
      rcw <= next_rcw;
      bank <= next_bank;
      addr <= next_addr;
      p_op <= next_op;
      p_bank <= next_pbank;
      p_addr <= next_paddr;
      active <= next_active;
      refs <= next_refs;
      ref_ph <= next_ref_ph;
      post <= next_post;
      tmr <= next_tmr;
      BUSY_O <= next_busy;
      ACK_O <= next_ack;
      REFUSE_O <= next_refuse;
      MODE_O <= next_mode;
    end
  end
endmodule

// ==== testbench/sdcmd_link_properties.sv ====
`timescale 1ns/100ps
module sdcmd_link_properties (
  input wire logic CORE_CLK_I,
  input wire logic ARST_N_I,
  input wire logic link_clk,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] bank_select,
  input wire logic [12:0] addr
);
  default clocking dc @(posedge CORE_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  logic link_d;
  logic ck_prev;
  logic [3:0] open_b;
  logic [2:0] last;
  logic [2:0] rcw;
  logic lr;
  logic take;
  logic sref_in;
  logic quiet;
  assign rcw = {ras_n, cas_n, we_n};
  assign lr = link_clk & ~link_d;
  assign take = lr & ck_prev & cke & ~cs_n & (rcw != sdcmd_pkg::RCW_NOP);
  assign sref_in = lr & ck_prev & ~cke & ~cs_n & (rcw == sdcmd_pkg::RCW_REF);
  assign quiet = cs_n | (rcw == sdcmd_pkg::RCW_NOP);
  // Open banks and last command as seen on the wire
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      link_d <= 1'b0;
      ck_prev <= 1'b0;
      open_b <= 4'h0;
      last <= 3'h7;
    end else begin
      link_d <= link_clk;
      if (lr)
        ck_prev <= cke;
      if (take) begin
        last <= rcw;
        if (rcw == sdcmd_pkg::RCW_ACT)
          open_b[bank_select] <= 1'b1;
        if (rcw == sdcmd_pkg::RCW_PRE && addr[sdcmd_pkg::PRECHARGE_SELECT_BIT])
          open_b <= 4'h0;
        else if (rcw == sdcmd_pkg::RCW_PRE || (rcw[2:1] == 2'h2 && addr[sdcmd_pkg::PRECHARGE_SELECT_BIT]))
          open_b[bank_select] <= 1'b0;
      end
    end
  end
  property p_pins_low;
    !$stable({cke, cs_n, rcw, bank_select, addr}) |-> !link_clk;
  endproperty
  a_pins_low: assert property (p_pins_low) else $error("link pins moved while clock high");
  property p_link_high;
    $rose(link_clk) |-> link_clk [*4] ##1 !link_clk;
  endproperty
  a_link_high: assert property (p_link_high) else $error("link clock high phase wrong");
  property p_sref_idle;
    sref_in |-> open_b == 4'h0;
  endproperty
  a_sref_idle: assert property (p_sref_idle) else $error("self refresh with open bank");
  property p_sref_after_ref;
    sref_in |-> last == sdcmd_pkg::RCW_REF;
  endproperty
  a_sref_after_ref: assert property (p_sref_after_ref) else $error("self refresh not after refresh");
  property p_lowpwr_quiet;
    lr && !ck_prev && !cke |-> quiet;
  endproperty
  a_lowpwr_quiet: assert property (p_lowpwr_quiet) else $error("command during low power");
  property p_wake_nop;
    lr && !ck_prev && cke |-> quiet;
  endproperty
  a_wake_nop: assert property (p_wake_nop) else $error("no idle command at wake edge");
  property p_wake_hold;
    lr && !ck_prev && cke |-> cke [*4];
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("clock enable dropped after wake");
  property p_rw_open;
    take && rcw[2:1] == 2'h2 |-> open_b[bank_select];
  endproperty
  a_rw_open: assert property (p_rw_open) else $error("access to idle bank");
  c_sref: cover property (sref_in);
  c_pdown: cover property (lr && ck_prev && !cke && !sref_in);
  c_read: cover property (take && rcw == sdcmd_pkg::RCW_READ);
  c_wake: cover property (lr && !ck_prev && cke);
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic req = 1'b0;
  sdcmd_pkg::sdcmd_op_e op = sdcmd_pkg::OP_NOP;
  logic [1:0] bank = 2'h0;
  logic [12:0] addr = 13'h0000;
  logic full_page = 1'b0;
  logic busy, ack, refuse, cmd_valid, auto_pre, burst, beat, clk_en;
  logic [3:0] act;
  sdcmd_pkg::sdcmd_mode_e h_mode, d_mode;
  sdcmd_pkg::sdcmd_op_e cmd, seen;
  int err_total = 0;
  int check_count = 0;
  int n_cmd = 0;
  int n_beat = 0;
  int n;
  int m;
  logic [1:0] d_bank;
  logic [12:0] d_addr;
  sdcmd_link_if lk();
  sdcmd_host #(.REFRESH_BURST(2), .PD_LIMIT(200)) sdcmd_host_i (.CORE_CLK_I(core_clk), .ARST_N_I(arst_n),
    .LINK(lk), .REQ_I(req), .OP_I(op), .BANK_I(bank), .ADDR_I(addr), .FULL_PAGE_I(full_page),
    .BUSY_O(busy), .ACK_O(ack), .REFUSE_O(refuse), .MODE_O(h_mode));
  sdcmd_dev sdcmd_dev_i (.CORE_CLK_I(core_clk), .ARST_N_I(arst_n), .LINK(lk), .FULL_PAGE_I(full_page),
    .CMD_VALID_O(cmd_valid), .CMD_O(cmd), .BANK_O(d_bank), .ADDR_O(d_addr), .AUTO_PRE_O(auto_pre),
    .BANK_ACTIVE_O(act), .BURST_ACTIVE_O(burst), .BURST_BEAT_O(beat), .MODE_O(d_mode), .INT_CLK_EN_O(clk_en));
  sdcmd_link_properties sdcmd_link_properties_i (.CORE_CLK_I(core_clk), .ARST_N_I(arst_n),
    .link_clk(lk.link_clk), .cke(lk.cke), .cs_n(lk.cs_n), .ras_n(lk.ras_n), .cas_n(lk.cas_n),
    .we_n(lk.we_n), .bank_select(lk.bank_select), .addr(lk.addr));
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (cmd_valid === 1'b1) begin
      seen <= cmd;
      n_cmd <= n_cmd + 1;
    end
    if (beat === 1'b1)
      n_beat <= n_beat + 1;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (e !== g) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  // One host request, then time for the device to decode it
  task automatic go(input sdcmd_pkg::sdcmd_op_e o, input logic [1:0] b, input logic [12:0] a, input logic rf);
    int i;
    @(negedge core_clk);
    op = o;
    bank = b;
    addr = a;
    req = 1'b1;
    @(negedge core_clk);
    req = 1'b0;
    i = 0;
    while (ack !== 1'b1 && refuse !== 1'b1 && i < 3000) begin
      @(negedge core_clk);
      i++;
    end
    chk("done", 16'h1, 16'(i < 3000));
    chk("refuse", 16'(rf), 16'(refuse));
    chk("busy", 16'h0, 16'(busy));
    repeat (16) @(negedge core_clk);
  endtask
  task automatic wait_burst;
    int i;
    i = 0;
    while (burst !== 1'b0 && i < 400) begin
      @(negedge core_clk);
      i++;
    end
    chk("burst_end", 16'h1, 16'(i < 400));
    // Last beat is counted one core cycle after it shows
    repeat (2) @(negedge core_clk);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge core_clk);
    err_total++;
    tally_and_finish;
  end
  initial begin
    repeat (16) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (16) @(negedge core_clk);
    chk("mode", 16'(sdcmd_pkg::MD_RUN), 16'(d_mode));
    go(sdcmd_pkg::OP_READ, 2'h1, 13'h0000, 1'b1);
    go(sdcmd_pkg::OP_ACT, 2'h1, 13'h0123, 1'b0);
    chk("op", 16'(sdcmd_pkg::OP_ACT), 16'(seen));
    chk("banks", 16'h2, 16'(act));
    chk("bank", 16'h1, 16'(d_bank));
    chk("addr", 16'h0123, 16'(d_addr));
    n = n_beat;
    go(sdcmd_pkg::OP_READ, 2'h1, 13'h0000, 1'b0);
    wait_burst;
    chk("beats", 16'(sdcmd_pkg::BURST_LEN), 16'(n_beat - n));
    chk("banks", 16'h2, 16'(act));
    go(sdcmd_pkg::OP_PDOWN, 2'h0, 13'h0000, 1'b0);
    chk("mode", 16'(sdcmd_pkg::MD_SUSP), 16'(d_mode));
    chk("h_mode", 16'(sdcmd_pkg::MD_SUSP), 16'(h_mode));
    go(sdcmd_pkg::OP_READ, 2'h1, 13'h0000, 1'b1);
    go(sdcmd_pkg::OP_WAKE, 2'h0, 13'h0000, 1'b0);
    chk("mode", 16'(sdcmd_pkg::MD_RUN), 16'(d_mode));
    n = n_beat;
    go(sdcmd_pkg::OP_READ, 2'h1, 13'h0000, 1'b0);
    go(sdcmd_pkg::OP_PDOWN, 2'h0, 13'h0000, 1'b0);
    chk("mode", 16'(sdcmd_pkg::MD_SUSP), 16'(d_mode));
    chk("clk_en", 16'h0, 16'(clk_en));
    chk("burst", 16'h1, 16'(burst));
    m = n_beat;
    repeat (24) @(negedge core_clk);
    chk("frozen", 16'(m), 16'(n_beat));
    go(sdcmd_pkg::OP_WAKE, 2'h0, 13'h0000, 1'b0);
    wait_burst;
    chk("beats", 16'(sdcmd_pkg::BURST_LEN), 16'(n_beat - n));
    go(sdcmd_pkg::OP_BST, 2'h1, 13'h0000, 1'b1);
    full_page = 1'b1;
    go(sdcmd_pkg::OP_READ, 2'h1, 13'h0000, 1'b0);
    go(sdcmd_pkg::OP_BST, 2'h1, 13'h0000, 1'b0);
    chk("op", 16'(sdcmd_pkg::OP_BST), 16'(seen));
    chk("burst", 16'h0, 16'(burst));
    full_page = 1'b0;
    go(sdcmd_pkg::OP_READ, 2'h1, 13'h0400, 1'b0);
    chk("ap", 16'h1, 16'(auto_pre));
    wait_burst;
    chk("banks", 16'h0, 16'(act));
    go(sdcmd_pkg::OP_ACT, 2'h0, 13'h0000, 1'b0);
    go(sdcmd_pkg::OP_ACT, 2'h3, 13'h0000, 1'b0);
    go(sdcmd_pkg::OP_PRE, 2'h0, 13'h0000, 1'b0);
    chk("banks", 16'h8, 16'(act));
    go(sdcmd_pkg::OP_PRE, 2'h1, 13'h0400, 1'b0);
    chk("banks", 16'h0, 16'(act));
    go(sdcmd_pkg::OP_MRS, 2'h0, 13'h0030, 1'b0);
    chk("op", 16'(sdcmd_pkg::OP_MRS), 16'(seen));
    go(sdcmd_pkg::OP_REF, 2'h0, 13'h0000, 1'b0);
    chk("op", 16'(sdcmd_pkg::OP_REF), 16'(seen));
    go(sdcmd_pkg::OP_PDOWN, 2'h0, 13'h0000, 1'b0);
    chk("mode", 16'(sdcmd_pkg::MD_PDOWN), 16'(d_mode));
    chk("h_mode", 16'(sdcmd_pkg::MD_PDOWN), 16'(h_mode));
    chk("clk_en", 16'h0, 16'(clk_en));
    go(sdcmd_pkg::OP_WAKE, 2'h0, 13'h0000, 1'b0);
    go(sdcmd_pkg::OP_ACT, 2'h2, 13'h0000, 1'b0);
    chk("op", 16'(sdcmd_pkg::OP_ACT), 16'(seen));
    go(sdcmd_pkg::OP_PDOWN, 2'h0, 13'h0000, 1'b0);
    repeat (260) @(negedge core_clk);
    chk("mode", 16'(sdcmd_pkg::MD_RUN), 16'(d_mode));
    n = n_cmd;
    go(sdcmd_pkg::OP_SREF, 2'h0, 13'h0000, 1'b0);
    chk("mode", 16'(sdcmd_pkg::MD_SREF), 16'(d_mode));
    chk("h_mode", 16'(sdcmd_pkg::MD_SREF), 16'(h_mode));
    chk("clk_en", 16'h0, 16'(clk_en));
    chk("cmds", 16'h4, 16'(n_cmd - n));
    go(sdcmd_pkg::OP_ACT, 2'h0, 13'h0000, 1'b1);
    n = n_cmd;
    go(sdcmd_pkg::OP_WAKE, 2'h0, 13'h0000, 1'b0);
    chk("mode", 16'(sdcmd_pkg::MD_RUN), 16'(d_mode));
    chk("h_mode", 16'(sdcmd_pkg::MD_RUN), 16'(h_mode));
    chk("cmds", 16'h2, 16'(n_cmd - n));
    chk("op", 16'(sdcmd_pkg::OP_REF), 16'(seen));
    go(sdcmd_pkg::OP_WAKE, 2'h0, 13'h0000, 1'b1);
    tally_and_finish;
  end
endmodule
